// *** verilog/pmw_window.sv ***
// Program memory data window: maps data space 40h-7Fh onto program memory
//
// What this block does
// (R1) Reads at data addresses 40h..7Fh return a program-memory byte.
// (R2) Window reaches any program byte from 0000h to 1FFFh.
// (R3) Window moves only in 64-byte steps set by the last base write.
// (R4) Base register takes ordinary data-space writes at address C9h.
// (R5) Program address is base bits above the six low data-address bits.
// (R6) Base register survives reset; its power-up value is undefined.
// (R7) Software writes the base register before any window read.
// (R8) Base register holds bits 6-0; bit 7 is unused.
// (R9) Software never reads it nor uses single-bit instructions on it.
// (R10) Interrupt handlers avoid it, or keep a RAM shadow written first.
// (R11) Written bit 7 is dropped and never affects address formation.
`timescale 1ns/1ns
`default_nettype none
module pmw_window (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire pmw_pkg::pmw_ds_req_t ds_req,
	output pmw_pkg::pmw_ds_rsp_t ds_rsp,
	output pmw_pkg::pmw_pm_req_t pm_req,
	input wire logic [pmw_pkg::DS_DW-1:0] pm_rdata
);
	logic base_hit;
	logic win_hit;
	logic [pmw_pkg::BASE_W-1:0] window_base_bits;
	logic [pmw_pkg::PM_AW-1:0] next_pm_addr;
	logic base_known;

	// Base register address match, shared by the decode and the checks
	function automatic logic is_base_addr(input logic [pmw_pkg::DS_AW-1:0] a);
		return a == pmw_pkg::WINDOW_BASE_SELECT_ADDR;
	endfunction

	// A read of the base address is not decoded: the register is write only
	assign base_hit = ds_req.wr && is_base_addr(ds_req.addr); // [R4]
	assign win_hit = ds_req.rd && pmw_pkg::pmw_in_window(ds_req.addr); // [R1]

	// Base bits on top, offset below: 64-byte granules over 13 bits
	for (genvar gi = 0; gi < pmw_pkg::PM_AW; gi++) begin : g_addr
		if (gi < pmw_pkg::OFS_W) begin : g_ofs
			assign next_pm_addr[gi] = ds_req.addr[gi]; // [R5]
		end else begin : g_base
			assign next_pm_addr[gi] =
				window_base_bits[gi - pmw_pkg::OFS_W]; // [R5] [R3] [R2]
		end
	end

	pmw_base_reg u_base (
		.clk(clk),
		.ce(ce),
		.wr_en(base_hit), // [R4] [R6]
		.wdata(ds_req.wdata), // [R8] [R11]
		.window_base_bits(window_base_bits)
	);

	// Stage one: present the fetch address to program memory.
	// Reset waits for the enable too, so a frozen core keeps its state.
	always_ff @(posedge clk) begin
		if (ce) begin
			if (srst) begin
				pm_req.rd <= 1'b0;
				pm_req.addr <= pmw_pkg::PM_ADDR_RST;
			end else begin
				pm_req.rd <= win_hit; // [R1]
				if (win_hit) begin
					pm_req.addr <= next_pm_addr; // [R5]
				end
			end
		end
	end

	// Stage two: array answers in the same cycle; capture for the core
	always_ff @(posedge clk) begin
		if (ce) begin
			if (srst) begin
				ds_rsp.rvalid <= 1'b0;
				ds_rsp.rdata <= pmw_pkg::RDATA_RST;
			end else begin
				ds_rsp.rvalid <= pm_req.rd; // [R1]
				if (pm_req.rd) begin
					ds_rsp.rdata <= pm_rdata;
				end
			end
		end
	end

	// Helper for assertions only: base has been loaded since power-up
	always_ff @(posedge clk) begin
		if (ce && base_hit) begin
			base_known <= 1'b1;
		end else if (base_known !== 1'b1) begin
			base_known <= 1'b0;
		end
	end

	sequence s_win_req;
		ce && ds_req.rd && !ds_req.wr && pmw_pkg::pmw_in_window(ds_req.addr);
	endsequence

	sequence s_base_wr;
		ce && ds_req.wr && is_base_addr(ds_req.addr);
	endsequence

	sequence s_no_win;
		ce && !(ds_req.rd && pmw_pkg::pmw_in_window(ds_req.addr));
	endsequence

	sequence s_fetch_done;
		ce && !pm_req.rd;
	endsequence

	a_window_read_answer: assert property (@(posedge clk) disable iff (srst) // [R1]
		s_win_req ##1 ce |=> ds_rsp.rvalid && ds_rsp.rdata == $past(pm_rdata))
		else $error("window read gave no answer two cycles later");

	a_outside_no_fetch: assert property (@(posedge clk) disable iff (srst) // [R1]
		(ce && !pmw_pkg::pmw_in_window(ds_req.addr)) |=> !pm_req.rd)
		else $error("program fetch issued for address outside window");

	a_addr_concat: assert property (@(posedge clk) disable iff (srst) // [R5]
		s_win_req |=> pm_req.rd &&
			pm_req.addr[pmw_pkg::OFS_W-1:0] == $past(ds_req.addr[5:0]))
		else $error("low fetch address bits do not match data address");

	a_addr_base_upper: assert property (@(posedge clk) disable iff (srst) // [R2]
		s_win_req |=> pm_req.addr[pmw_pkg::PM_AW-1:pmw_pkg::OFS_W]
			== $past(window_base_bits))
		else $error("upper fetch address bits do not follow base");

	a_base_write_taken: assert property (@(posedge clk) disable iff (srst) // [R4]
		s_base_wr |=> window_base_bits == $past(ds_req.wdata[6:0]))
		else $error("base write at C9h was not stored");

	a_base_moves_only_wr: assert property (@(posedge clk) disable iff (srst) // [R3]
		(base_known && !(ce && base_hit)) |=> $stable(window_base_bits))
		else $error("window base changed without a base write");

	a_base_kept_reset: assert property (@(posedge clk) // [R6]
		(srst && base_known) |=> $stable(window_base_bits))
		else $error("reset disturbed the window base register");

	a_bit7_ignored: assert property (@(posedge clk) disable iff (srst) // [R11]
		s_base_wr ##1 s_win_req |=> pm_req.addr[pmw_pkg::PM_AW-1:pmw_pkg::OFS_W]
			== $past(ds_req.wdata[6:0], 2))
		else $error("fetch address affected by unused base bit 7");

	a_frozen_ce_low: assert property (@(posedge clk) disable iff (srst) // [R6]
		!ce |=> $stable(pm_req) && $stable(ds_rsp) && $stable(window_base_bits))
		else $error("state moved while clock enable was low");

	// The checks below cover the pipeline and the base register between reads and around reset

	a_reset_clears_out: assert property (@(posedge clk) // [R1]
		(srst && ce) |=> !pm_req.rd && !ds_rsp.rvalid &&
			pm_req.addr == pmw_pkg::PM_ADDR_RST &&
			ds_rsp.rdata == pmw_pkg::RDATA_RST)
		else $error("reset left the pipeline outputs set");

	a_ce_blocks_reset: assert property (@(posedge clk) // [R6]
		(srst && !ce) |=> $stable(pm_req) && $stable(ds_rsp))
		else $error("reset acted while clock enable was low");

	a_rvalid_follows: assert property (@(posedge clk) // [R1]
		disable iff (srst)
		ce |=> ds_rsp.rvalid == $past(pm_req.rd))
		else $error("read answer does not follow the fetch");

	a_write_no_fetch: assert property (@(posedge clk) // [R4]
		disable iff (srst)
		(ce && ds_req.wr) |=> !pm_req.rd)
		else $error("a write access started a program fetch");

	a_fetch_needs_read: assert property (@(posedge clk) // [R1]
		disable iff (srst)
		(ce && !ds_req.rd) |=> !pm_req.rd)
		else $error("program fetch issued without a read");

	a_fetch_pulse: assert property (@(posedge clk) // [R1]
		disable iff (srst)
		pm_req.rd ##0 s_no_win |=> !pm_req.rd)
		else $error("program fetch strobe stood too long");

	a_addr_holds: assert property (@(posedge clk) // [R5]
		disable iff (srst)
		s_no_win |=> $stable(pm_req.addr))
		else $error("fetch address moved without a window read");

	a_rdata_holds: assert property (@(posedge clk) // [R1]
		disable iff (srst)
		s_fetch_done |=> $stable(ds_rsp.rdata))
		else $error("read data moved without a fetch");

	a_rvalid_pulse: assert property (@(posedge clk) // [R1]
		disable iff (srst)
		s_fetch_done |=> !ds_rsp.rvalid)
		else $error("read answer given without a fetch");

	a_write_no_answer: assert property (@(posedge clk) // [R4]
		disable iff (srst)
		s_base_wr ##1 ce |=> !ds_rsp.rvalid)
		else $error("a base write produced a read answer");

	a_base_read_ignored: assert property (@(posedge clk) // [R4]
		(ce && ds_req.rd && is_base_addr(ds_req.addr) && base_known)
			|=> $stable(window_base_bits))
		else $error("a read of the base address changed the base");

	// No reset term here: the base must ride through reset untouched
	a_base_keep_no_ce: assert property (@(posedge clk) // [R6]
		(base_known && !ce) |=> $stable(window_base_bits))
		else $error("window base moved while clock enable was low");
endmodule
`default_nettype wire

// *** verilog/pmw_pkg.sv ***
// Constants and carrier types for the program memory data window
package pmw_pkg;
	localparam int DS_AW = 8;
	localparam int DS_DW = 8;
	localparam int OFS_W = 6;
	localparam int BASE_W = 7;
	localparam int PM_AW = OFS_W + BASE_W;
	localparam logic [DS_AW-1:0] WIN_LO = 8'h40;
	localparam logic [DS_AW-1:0] WIN_HI = 8'h7f;
	localparam logic [DS_AW-1:0] WINDOW_BASE_SELECT_ADDR = 8'hc9;
	localparam int BASE_LSB = 0;
	localparam int BASE_MSB = 6;
	localparam logic [PM_AW-1:0] PM_TOP = 13'h1fff;
	localparam logic [PM_AW-1:0] PM_ADDR_RST = 13'h0000;
	localparam logic [DS_DW-1:0] RDATA_RST = 8'h00;

	// One data-space access from the core
	typedef struct packed {
		logic [DS_AW-1:0] addr;
		logic [DS_DW-1:0] wdata;
		logic rd;
		logic wr;
	} pmw_ds_req_t;

	// Read answer back to the core
	typedef struct packed {
		logic [DS_DW-1:0] rdata;
		logic rvalid;
	} pmw_ds_rsp_t;

	// Fetch request toward the program memory array
	typedef struct packed {
		logic [PM_AW-1:0] addr;
		logic rd;
	} pmw_pm_req_t;

	function automatic logic pmw_in_window(input logic [DS_AW-1:0] a);
		return (a >= WIN_LO) && (a <= WIN_HI);
	endfunction
endpackage

// *** verilog/pmw_base_reg.sv ***
// Window base select register, write only and never reset
`timescale 1ns/1ns
`default_nettype none
module pmw_base_reg (
	input wire logic clk,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [pmw_pkg::DS_DW-1:0] wdata,
	output logic [pmw_pkg::BASE_W-1:0] window_base_bits
);
	// No reset term: software must load it before the first window read
	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			window_base_bits <= wdata[pmw_pkg::BASE_MSB:pmw_pkg::BASE_LSB];
		end
	end
endmodule
`default_nettype wire

// *** bench/pmw_pmem.sv ***
// Program memory model answering window fetches
`timescale 1ns/1ns
`default_nettype none
module pmw_pmem (
	input wire pmw_pkg::pmw_pm_req_t pm_req,
	output logic [pmw_pkg::DS_DW-1:0] pm_rdata
);
	logic [7:0] byte_at;
	assign byte_at = pm_req.addr[7:0] ^ {3'h0, pm_req.addr[12:8]};
	// Outside a fetch the bus shows the inverse, so a late sample shows up
	assign pm_rdata = pm_req.rd ? byte_at : ~byte_at;
endmodule
`default_nettype wire

// *** bench/pmw_window_tb.sv ***
// Bench for the program memory data window
`timescale 1ns/1ns
`default_nettype none
module pmw_window_tb;
	logic clk, srst, ce;
	pmw_pkg::pmw_ds_req_t req;
	pmw_pkg::pmw_ds_rsp_t rsp;
	pmw_pkg::pmw_pm_req_t pmq;
	logic [7:0] pmd;
	logic [7:0] shadow;
	int bad_count, n_tests;
	pmw_window DUT(.clk(clk), .srst(srst), .ce(ce), .ds_req(req),
		.ds_rsp(rsp), .pm_req(pmq), .pm_rdata(pmd));
	pmw_pmem MEM(.pm_req(pmq), .pm_rdata(pmd));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	function automatic logic [7:0] pat(input logic [12:0] a);
		return a[7:0] ^ {3'h0, a[12:8]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [7:0] a, input logic [7:0] d,
		input logic w);
		@(negedge clk);
		req = '{a, d, ~w, w};
		@(negedge clk);
		req = '0;
	endtask
	// Bounded wait; ok low means no fetch and no answer may appear
	task automatic rd(input logic [7:0] a, input logic [12:0] pa,
		input logic ok);
		int i;
		logic got;
		got = 0;
		acc(a, 8'h00, 1'b0);
		for (i = 0; i < 4; i++) begin
			if (pmq.rd === 1'b1) chk(pmq.addr, pa);
			if (rsp.rvalid === 1'b1) begin
				got = 1;
				chk(rsp.rdata, pat(pa));
			end
			@(negedge clk);
		end
		chk(got, ok);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		srst = 1;
		ce = 1;
		req = '0;
		bad_count = 0;
		n_tests = 0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		srst = 0;
		acc(8'hc9, 8'h83, 1'b1);
		rd(8'h45, 13'h00c5, 1'b1);
		shadow = 8'h7f;
		acc(8'hc9, shadow, 1'b1);
		rd(8'h7f, 13'h1fff, 1'b1);
		rd(8'h40, 13'h1fc0, 1'b1);
		$display("test mapping done");
		acc(8'hc8, 8'h00, 1'b1);
		rd(8'h41, 13'h1fc1, 1'b1);
		rd(8'h80, 13'h0000, 1'b0);
		rd(8'h3f, 13'h0000, 1'b0);
		rd(8'hbf, 13'h0000, 1'b0);
		$display("test refusals done");
		// Enable low freezes a fetch in flight, reset included
		@(negedge clk);
		req = '{8'h44, 8'h00, 1'b1, 1'b0};
		@(negedge clk);
		req = '0;
		ce = 0;
		srst = 1;
		@(negedge clk);
		srst = 0;
		chk(pmq.rd, 1'b1);
		chk(rsp.rvalid, 1'b0);
		ce = 1;
		@(negedge clk);
		chk(rsp.rvalid, 1'b1);
		chk(rsp.rdata, pat(13'h1fc4));
		$display("test clock enable done");
		srst = 1;
		@(negedge clk);
		srst = 0;
		chk({rsp.rvalid, pmq.rd}, 2'b00);
		chk(rsp.rdata, pmw_pkg::RDATA_RST);
		chk(pmq.addr, pmw_pkg::PM_ADDR_RST);
		rd(8'h42, 13'h1fc2, 1'b1);
		$display("test reset retention done");
		print_verdict;
	end
endmodule
`default_nettype wire
